//--- design/trb_telemetry_bank.sv
// read-only telemetry register bank with live, latched, interrupt and averaged views
`timescale 1ns/100ps

module trb_telemetry_bank
    import trb_pkg::*;
(
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_rst,
    input  wire trb_live_s                i_live,
    input  wire trb_evt_s                 i_evt,
    input  wire logic                     i_rec_clr,
    input  wire logic [TRB_INT_SRC_N-1:0] i_int_evt,
    input  wire logic [TRB_INT_SRC_N-1:0] i_int_mask,
    input  wire logic                     i_int_clr,
    input  wire logic [TRB_CUR_W-1:0]     i_cur_sample,
    input  wire logic                     i_cur_valid,
    input  wire logic [TRB_VOLT_W-1:0]    i_volt_sample,
    input  wire logic                     i_volt_valid,
    input  wire logic [15:0]              i_fault_resp,
    input  wire logic [15:0]              i_dac_setting,
    input  wire logic                     i_ptr_wr,
    input  wire logic [7:0]               i_ptr_addr,
    input  wire logic                     i_rd_req,
    output logic [15:0]                   o_rd_data,
    output logic                          o_rd_valid
);

    // ==========================================================
    // helpers
    function automatic logic [TRB_CUR_W-1:0] avg_cur(input logic [TRB_CUR_SUM_W-1:0] s);
        avg_cur = s[TRB_CUR_SUM_W-1:TRB_AVG_LOG2];
    endfunction

    function automatic logic [TRB_VOLT_W-1:0] avg_volt(input logic [TRB_VOLT_SUM_W-1:0] s);
        avg_volt = s[TRB_VOLT_SUM_W-1:TRB_AVG_LOG2];
    endfunction

    trb_state_s q_ff;
    trb_state_s nxt_q;
    logic [15:0] live_word;
    logic [15:0] rd_word;
    logic [15:0] lat_set;

    // ==========================================================
    // next state
    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.sync1 = i_live;
        nxt_q.sync2 = q_ff.sync1;

        live_word = TRB_WORD_ZERO;
        live_word[TRB_LIVE_OV_BIT]    = q_ff.sync2.overvoltage_comparator;
        live_word[TRB_LIVE_UV_BIT]    = q_ff.sync2.undervoltage_comparator;
        live_word[TRB_LIVE_SHORT_BIT] = q_ff.sync2.sense_pin_short;
        live_word[TRB_LIVE_READY_BIT] = q_ff.sync2.ready;

        // sticky records: a new event wins over a clear in the same cycle
        lat_set = TRB_WORD_ZERO;
        lat_set[TRB_LAT_TURNOFF_BIT] = i_evt.turnoff_command_seen;
        lat_set[TRB_LAT_LO_OV_BIT]  = i_evt.overvoltage_latchoff;
        lat_set[TRB_LAT_LO_UV_BIT]  = i_evt.undervoltage_latchoff;
        lat_set[TRB_LAT_AR_OV_BIT]  = i_evt.overvoltage_restart;
        lat_set[TRB_LAT_AR_UV_BIT]  = i_evt.undervoltage_restart;
        nxt_q.latched = (i_rec_clr ? TRB_WORD_ZERO : q_ff.latched) | lat_set;

        // masked sources never reach the status bits
        nxt_q.int_stat = (i_int_clr ? '0 : q_ff.int_stat) | (i_int_evt & i_int_mask);

        // running sums over a sixteen-entry history
        if (i_cur_valid)
        begin
            nxt_q.cur_sum = q_ff.cur_sum + TRB_CUR_SUM_W'(i_cur_sample)
                            - TRB_CUR_SUM_W'(q_ff.cur_hist[q_ff.cur_idx]);
            nxt_q.cur_hist[q_ff.cur_idx] = i_cur_sample;
            nxt_q.cur_idx = q_ff.cur_idx + 1'b1;
            nxt_q.cur_last = i_cur_sample;
        end
        if (i_volt_valid)
        begin
            nxt_q.volt_sum = q_ff.volt_sum + TRB_VOLT_SUM_W'(i_volt_sample)
                             - TRB_VOLT_SUM_W'(q_ff.volt_hist[q_ff.volt_idx]);
            nxt_q.volt_hist[q_ff.volt_idx] = i_volt_sample;
            nxt_q.volt_idx = q_ff.volt_idx + 1'b1;
            nxt_q.volt_last = i_volt_sample;
        end

        if (i_ptr_wr)
        begin
            nxt_q.ptr = i_ptr_addr;
        end

        // read mux on the current pointer
        if (q_ff.ptr == TRB_ADDR_FAULT_RESP)
            rd_word = i_fault_resp;
        else if (q_ff.ptr == TRB_ADDR_MEAS_CUR)
            rd_word = {8'h00, q_ff.cur_last};
        else if (q_ff.ptr == TRB_ADDR_MEAS_VOLT)
            rd_word = {4'h0, q_ff.volt_last};
        else if (q_ff.ptr == TRB_ADDR_LIVE)
            rd_word = live_word;
        else if (q_ff.ptr == TRB_ADDR_LATCHED)
            rd_word = q_ff.latched;
        else if (q_ff.ptr == TRB_ADDR_INT)
            rd_word = {1'b0, i_int_mask, 1'b0, q_ff.int_stat};
        else if (q_ff.ptr == TRB_ADDR_AVG_CUR)
            rd_word = {8'h00, avg_cur(q_ff.cur_sum)};
        else if (q_ff.ptr == TRB_ADDR_AVG_VOLT)
            rd_word = {4'h0, avg_volt(q_ff.volt_sum)};
        else if (q_ff.ptr == TRB_ADDR_DAC)
            rd_word = i_dac_setting;
        else
            rd_word = TRB_WORD_ZERO;

        nxt_q.rd_valid = i_rd_req;
        if (i_rd_req)
        begin
            nxt_q.rd_data = rd_word;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            q_ff     <= '0;
            q_ff.ptr <= TRB_PTR_RESET;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    assign o_rd_data  = q_ff.rd_data;
    assign o_rd_valid = q_ff.rd_valid;

    // ==========================================================
    // checks
    property p_avg_cur;
        @(posedge i_clk_sys) disable iff (i_rst)
        (i_rd_req && !i_ptr_wr && q_ff.ptr == TRB_ADDR_AVG_CUR)
        |=> (o_rd_data == {8'h00, $past(q_ff.cur_sum[TRB_CUR_SUM_W-1:TRB_AVG_LOG2])}) && o_rd_valid;
    endproperty
    a_avg_cur: assert property (p_avg_cur) else $error("average current word wrong");

    property p_avg_volt;
        @(posedge i_clk_sys) disable iff (i_rst)
        (i_rd_req && q_ff.ptr == TRB_ADDR_AVG_VOLT)
        |=> (o_rd_data[15:12] == 4'h0)
            && (o_rd_data[11:0] == $past(q_ff.volt_sum[TRB_VOLT_SUM_W-1:TRB_AVG_LOG2]));
    endproperty
    a_avg_volt: assert property (p_avg_volt) else $error("average voltage word wrong");

    property p_live_uv;
        @(posedge i_clk_sys) disable iff (i_rst)
        (i_rd_req && q_ff.ptr == TRB_ADDR_LIVE)
        |=> o_rd_data[TRB_LIVE_UV_BIT] == $past(i_live.undervoltage_comparator, 3);
    endproperty
    a_live_uv: assert property (p_live_uv) else $error("live undervoltage bit wrong");

    property p_live_ov;
        @(posedge i_clk_sys) disable iff (i_rst)
        (i_rd_req && q_ff.ptr == TRB_ADDR_LIVE)
        |=> o_rd_data[TRB_LIVE_OV_BIT] == $past(i_live.overvoltage_comparator, 3);
    endproperty
    a_live_ov: assert property (p_live_ov) else $error("live overvoltage bit wrong");

    property p_live_short;
        @(posedge i_clk_sys) disable iff (i_rst)
        (i_rd_req && q_ff.ptr == TRB_ADDR_LIVE)
        |=> o_rd_data[TRB_LIVE_SHORT_BIT] == $past(i_live.sense_pin_short, 3);
    endproperty
    a_live_short: assert property (p_live_short) else $error("live sense short bit wrong");

    property p_turnoff;
        @(posedge i_clk_sys) disable iff (i_rst)
        i_evt.turnoff_command_seen ##1 !i_rec_clr [*2] |=> q_ff.latched[TRB_LAT_TURNOFF_BIT];
    endproperty
    a_turnoff: assert property (p_turnoff) else $error("turn-off record lost");

    property p_lo_ov;
        @(posedge i_clk_sys) disable iff (i_rst)
        (q_ff.latched[TRB_LAT_LO_OV_BIT] && !i_rec_clr) || i_evt.overvoltage_latchoff
        |=> q_ff.latched[TRB_LAT_LO_OV_BIT];
    endproperty
    a_lo_ov: assert property (p_lo_ov) else $error("overvoltage latch-off record lost");

    property p_lo_uv;
        @(posedge i_clk_sys) disable iff (i_rst)
        $rose(q_ff.latched[TRB_LAT_LO_UV_BIT]) |-> $past(i_evt.undervoltage_latchoff);
    endproperty
    a_lo_uv: assert property (p_lo_uv) else $error("undervoltage latch-off record set without cause");

    property p_ar_ov;
        @(posedge i_clk_sys) disable iff (i_rst)
        i_evt.overvoltage_restart
        |=> q_ff.latched[TRB_LAT_AR_OV_BIT] && (o_rd_valid == $past(i_rd_req));
    endproperty
    a_ar_ov: assert property (p_ar_ov) else $error("overvoltage restart record missing");

    property p_ar_uv;
        @(posedge i_clk_sys) disable iff (i_rst)
        (q_ff.latched[TRB_LAT_AR_UV_BIT] && !i_rec_clr) |=> q_ff.latched[TRB_LAT_AR_UV_BIT];
    endproperty
    a_ar_uv: assert property (p_ar_uv) else $error("undervoltage restart record dropped");

    property p_int_mask;
        @(posedge i_clk_sys) disable iff (i_rst)
        1'b1 |=> ((q_ff.int_stat & ~$past(q_ff.int_stat) & ~$past(i_int_mask)) == '0);
    endproperty
    a_int_mask: assert property (p_int_mask) else $error("masked source set a status bit");

endmodule

//--- design/trb_pkg.sv
// shared constants and carrier types for the telemetry read-back bank
package trb_pkg;

    // ==========================================================
    // register sub-addresses
    localparam logic [7:0] TRB_ADDR_FAULT_RESP  = 8'h0c;
    localparam logic [7:0] TRB_ADDR_MEAS_CUR    = 8'h0e;
    localparam logic [7:0] TRB_ADDR_MEAS_VOLT   = 8'h12;
    localparam logic [7:0] TRB_ADDR_LIVE        = 8'h14;
    localparam logic [7:0] TRB_ADDR_LATCHED     = 8'h16;
    localparam logic [7:0] TRB_ADDR_INT         = 8'h18;
    localparam logic [7:0] TRB_ADDR_AVG_CUR     = 8'h1a;
    localparam logic [7:0] TRB_ADDR_AVG_VOLT    = 8'h1c;
    localparam logic [7:0] TRB_ADDR_DAC         = 8'h5c;
    localparam logic [7:0] TRB_PTR_RESET        = 8'h14;

    // ==========================================================
    // field positions
    localparam int TRB_LIVE_OV_BIT    = 0;
    localparam int TRB_LIVE_UV_BIT    = 1;
    localparam int TRB_LIVE_SHORT_BIT = 3;
    localparam int TRB_LIVE_READY_BIT = 14;
    localparam int TRB_LAT_LO_UV_BIT  = 1;
    localparam int TRB_LAT_LO_OV_BIT  = 2;
    localparam int TRB_LAT_TURNOFF_BIT = 5;
    localparam int TRB_LAT_AR_UV_BIT  = 9;
    localparam int TRB_LAT_AR_OV_BIT  = 10;
    localparam int TRB_INT_MASK_SHIFT = 8;
    localparam int TRB_INT_SRC_N      = 7;

    // ==========================================================
    // widths and averaging
    localparam int TRB_CUR_W      = 8;
    localparam int TRB_VOLT_W     = 12;
    localparam int TRB_AVG_LOG2   = 4;
    localparam int TRB_AVG_DEPTH  = 16;
    localparam int TRB_CUR_SUM_W  = TRB_CUR_W + TRB_AVG_LOG2;
    localparam int TRB_VOLT_SUM_W = TRB_VOLT_W + TRB_AVG_LOG2;
    localparam logic [15:0] TRB_WORD_ZERO = 16'h0000;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic ready;
        logic sense_pin_short;
        logic undervoltage_comparator;
        logic overvoltage_comparator;
    } trb_live_s;

    typedef struct packed {
        logic turnoff_command_seen;
        logic overvoltage_latchoff;
        logic undervoltage_latchoff;
        logic overvoltage_restart;
        logic undervoltage_restart;
    } trb_evt_s;

    typedef struct packed {
        trb_live_s                                  sync1;
        trb_live_s                                  sync2;
        logic [7:0]                                 ptr;
        logic [15:0]                                latched;
        logic [TRB_INT_SRC_N-1:0]                   int_stat;
        logic [TRB_AVG_DEPTH-1:0][TRB_CUR_W-1:0]    cur_hist;
        logic [TRB_AVG_DEPTH-1:0][TRB_VOLT_W-1:0]   volt_hist;
        logic [TRB_AVG_LOG2-1:0]                    cur_idx;
        logic [TRB_AVG_LOG2-1:0]                    volt_idx;
        logic [TRB_CUR_SUM_W-1:0]                   cur_sum;
        logic [TRB_VOLT_SUM_W-1:0]                  volt_sum;
        logic [TRB_CUR_W-1:0]                       cur_last;
        logic [TRB_VOLT_W-1:0]                      volt_last;
        logic [15:0]                                rd_data;
        logic                                       rd_valid;
    } trb_state_s;

endpackage

//--- test/trb_host_model.sv
// host-side model that reads telemetry words through the read pointer
`timescale 1ns/100ps
module trb_host_model
    import trb_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic [15:0] i_rd_data,
    input  wire logic        i_rd_valid,
    output logic             o_ptr_wr,
    output logic [7:0]       o_ptr_addr,
    output logic             o_rd_req
);
    initial
    begin
        o_ptr_wr = 1'b0;
        o_ptr_addr = 8'h00;
        o_rd_req = 1'b0;
    end
    // ==========================================================
    // pointer load, then the read one cycle later
    task automatic read_word(input logic [7:0] addr, output logic [15:0] data, output logic ok);
        ok = 1'b0;
        data = 16'h0000;
        @(posedge i_clk_sys);
        o_ptr_wr <= 1'b1;
        o_ptr_addr <= addr;
        @(posedge i_clk_sys);
        o_ptr_wr <= 1'b0;
        o_ptr_addr <= ~addr;
        o_rd_req <= 1'b1;
        @(posedge i_clk_sys);
        o_rd_req <= 1'b0;
        // answer is taken at the rising edge where valid is sampled high
        for (int n = 0; n < 4 && !ok; n++)
        begin
            @(posedge i_clk_sys);
            if (i_rd_valid === 1'b1)
            begin
                data = i_rd_data;
                ok = 1'b1;
            end
        end
    endtask
    // ==========================================================
    // poll the ready bit before any other traffic
    task automatic wait_ready(output logic ok);
        logic [15:0] d;
        logic        r;
        ok = 1'b0;
        for (int n = 0; n < 8 && !ok; n++)
        begin
            read_word(TRB_ADDR_LIVE, d, r);
            ok = (r === 1'b1) && (d[TRB_LIVE_READY_BIT] === 1'b1);
        end
    endtask
endmodule

//--- test/tb_top.sv
// self-checking bench for the telemetry read-back bank
`timescale 1ns/100ps
module tb_top
    import trb_pkg::*;
;
    logic clk, rst, rec_clr, int_clr, cur_v, volt_v, ptr_wr, rd_req, rd_valid, ok;
    trb_live_s live;
    trb_evt_s evt;
    logic [6:0] int_evt, int_mask;
    logic [7:0] cur, ptr_addr;
    logic [11:0] volt;
    logic [15:0] fault_resp, dac, rd_data, d;
    int errors = 0;
    int check_count = 0;
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    trb_telemetry_bank DUT (.i_clk_sys(clk), .i_rst(rst), .i_live(live), .i_evt(evt), .i_rec_clr(rec_clr),
        .i_int_evt(int_evt), .i_int_mask(int_mask), .i_int_clr(int_clr), .i_cur_sample(cur),
        .i_cur_valid(cur_v), .i_volt_sample(volt), .i_volt_valid(volt_v), .i_fault_resp(fault_resp),
        .i_dac_setting(dac), .i_ptr_wr(ptr_wr), .i_ptr_addr(ptr_addr), .i_rd_req(rd_req),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid));
    trb_host_model host (.i_clk_sys(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .o_ptr_wr(ptr_wr),
        .o_ptr_addr(ptr_addr), .o_rd_req(rd_req));
    // ==========================================================
    // shared helpers
    task automatic print_verdict();
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: read %h, want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        logic r;
        host.read_word(a, v, r);
        if (r !== 1'b1)
        begin
            errors++;
            $display("unexpected at %0t: no read answer", $time);
            print_verdict();
        end
    endtask
    // ==========================================================
    // scenarios
    task automatic test_live();
        for (int k = 0; k < 3; k++)
        begin
            live <= trb_live_s'({1'b1, 3'(1 << k)});
            tick(3);
            rd(TRB_ADDR_LIVE, d);
            chk(d, 16'h4000 | ((k == 2) ? 16'h0008 : 16'(1 << k)));
        end
        live <= trb_live_s'(4'h8);
        tick(3);
        rd(TRB_ADDR_LIVE, d);
        chk(d, 16'h4000);
    endtask
    task automatic test_latched();
        logic [4:0][15:0] pos = {16'h0020, 16'h0004, 16'h0002, 16'h0400, 16'h0200};
        logic [15:0]      exp = 16'h0000;
        for (int k = 0; k < 5; k++)
        begin
            evt <= trb_evt_s'(5'(1 << k));
            tick(1);
            evt <= trb_evt_s'(5'h00);
            exp = exp | pos[k];
            tick(2);
            rd(TRB_ADDR_LATCHED, d);
            chk(d, exp);
        end
        evt <= trb_evt_s'(5'h10);
        rec_clr <= 1'b1;
        tick(1);
        evt <= trb_evt_s'(5'h00);
        rec_clr <= 1'b0;
        rd(TRB_ADDR_LATCHED, d);
        chk(d, 16'h0020);
    endtask
    task automatic test_int();
        int_mask <= 7'h55;
        int_evt <= 7'h7f;
        tick(1);
        int_evt <= 7'h00;
        rd(TRB_ADDR_INT, d);
        chk(d, 16'h5555);
        int_clr <= 1'b1;
        tick(1);
        int_clr <= 1'b0;
        int_mask <= 7'h2a;
        rd(TRB_ADDR_INT, d);
        chk(d, 16'h2a00);
        int_evt <= 7'h7f;
        tick(1);
        int_evt <= 7'h00;
        rd(TRB_ADDR_INT, d);
        chk(d, 16'h2a2a);
    endtask
    task automatic test_avg();
        for (int k = 0; k < 20; k++)
        begin
            cur <= (k < 4) ? 8'hff : 8'((k - 4) * 16);
            volt <= (k < 4) ? 12'hfff : 12'((k - 4) * 256);
            cur_v <= 1'b1;
            volt_v <= 1'b1;
            tick(1);
        end
        cur_v <= 1'b0;
        volt_v <= 1'b0;
        tick(2);
        rd(TRB_ADDR_AVG_CUR, d);
        chk(d, 16'h0078);
        rd(TRB_ADDR_AVG_VOLT, d);
        chk(d, 16'h0780);
        rd(TRB_ADDR_MEAS_VOLT, d);
        chk(d, 16'h0f00);
        rd(TRB_ADDR_MEAS_CUR, d);
        chk(d, 16'h00f0);
        rd(TRB_ADDR_FAULT_RESP, d);
        chk(d, 16'ha5c3);
        rd(TRB_ADDR_DAC, d);
        chk(d, 16'h3c5a);
        rd(8'h20, d);
        chk(d, 16'h0000);
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        {rec_clr, int_clr, cur_v, volt_v, int_evt, int_mask, cur, volt} = '0;
        live = trb_live_s'(4'h0);
        evt = trb_evt_s'(5'h00);
        fault_resp = 16'ha5c3;
        dac = 16'h3c5a;
        tick(12);
        chk(rd_data, 16'h0000);
        chk({15'h0000, rd_valid}, 16'h0000);
        rst <= 1'b0;
        live <= trb_live_s'(4'h8);
        host.wait_ready(ok);
        chk({15'h0000, ok}, 16'h0001);
        test_live();
        test_latched();
        test_int();
        test_avg();
        print_verdict();
    end
endmodule
